// [common/slrx_defines.vh]
// register offsets, field positions, reset values and timing for the receiver setup bank
// assumes a 15-bit register address carried by the serial control port
`ifndef SLRX_DEFINES_VH
`define SLRX_DEFINES_VH

// ============================================================
// serial control port framing
`define SLRX_ADDR_W          15
`define SLRX_INSTR_BITS      5'h10
`define SLRX_FRAME_BITS      5'h18

// ============================================================
// datapath step
`define SLRX_SAMPLE_FORMAT   15'h0110
`define SLRX_INTERP_SELECT   15'h0112
`define SLRX_FMT_BIT         7

// ============================================================
// physical layer and power
`define SLRX_IFACE_POWER     15'h0200
`define SLRX_UNUSED_LANES    15'h0201
`define SLRX_RECOVERY_RESET  15'h0206
`define SLRX_RECOVERY_CFG    15'h0230
`define SLRX_EQUALIZER       15'h0268
`define SLRX_PLL_ENABLE      15'h0280
`define SLRX_PLL_STATUS      15'h0281
`define SLRX_PLL_FILTER_A    15'h0284
`define SLRX_PLL_FILTER_B    15'h0285
`define SLRX_PLL_FILTER_C    15'h0286
`define SLRX_PLL_PUMP_A      15'h0287
`define SLRX_PLL_DIVIDER     15'h0289
`define SLRX_PLL_VCO_LDO     15'h028A
`define SLRX_PLL_CONFIG_A    15'h028B
`define SLRX_PLL_VARACTOR_A  15'h0290
`define SLRX_PLL_PUMP_B      15'h0294
`define SLRX_PLL_VCO_A       15'h0296
`define SLRX_PLL_VCO_B       15'h0297
`define SLRX_PLL_CONFIG_B    15'h0299
`define SLRX_PLL_VARACTOR_B  15'h029A
`define SLRX_PLL_PUMP_C      15'h029C
`define SLRX_PLL_VARACTOR_C  15'h029F
`define SLRX_PLL_VARACTOR_D  15'h02A0
`define SLRX_AUTOTUNE_A      15'h02A7
`define SLRX_TERM_A_LOW      15'h02AA
`define SLRX_TERM_A_HIGH     15'h02AB
`define SLRX_AUTOTUNE_B      15'h02AE
`define SLRX_TERM_B_LOW      15'h02B1
`define SLRX_TERM_B_HIGH     15'h02B2
`define SLRX_LINK_CONTROL    15'h0300
`define SLRX_PORT_CONFIG     15'h0314

// ============================================================
// per-link transport registers
`define SLRX_DEVICE_ID       15'h0450
`define SLRX_BANK_ID         15'h0451
`define SLRX_LANE_ID         15'h0452
`define SLRX_LANE_COUNT      15'h0453
`define SLRX_OCTETS          15'h0454
`define SLRX_FRAMES          15'h0455
`define SLRX_CONVERTERS      15'h0456
`define SLRX_RESOLUTION      15'h0457
`define SLRX_SAMPLE_BITS     15'h0458
`define SLRX_VERSION         15'h0459
`define SLRX_DENSITY         15'h045A
`define SLRX_LANE_SUM        15'h045D
`define SLRX_LANE_DESKEW     15'h046C
`define SLRX_FRAME_OCTETS    15'h0476
`define SLRX_LANE_ENABLE     15'h047D

// ============================================================
// field positions
`define SLRX_LSB_BIT         0
`define SLRX_OVERSAMPLE_SEL_BIT       1
`define SLRX_PAGE_BIT        2
`define SLRX_DUAL_BIT        3
`define SLRX_HALF_BIT        5
`define SLRX_SUM_BIT         6
`define SLRX_DIV_RANGE       1:0
`define SLRX_EQ_RANGE        7:6
`define SLRX_VER_RANGE       7:5
`define SLRX_VER_B           3'h1

// ============================================================
// reset values and fixed values
`define SLRX_RST_ZERO        8'h00
`define SLRX_RST_RECOVERY    8'h08
`define SLRX_RST_DIVIDER     8'h04
`define SLRX_RST_EQUALIZER   8'h22
`define SLRX_RST_CDR         8'h01
`define SLRX_POWER_ON_VALUE  8'h00

// ============================================================
// timing: time from pll enable to lock report
`define SLRX_CLK_MHZ         25
`define SLRX_LOCK_NS         20000
`define SLRX_LOCK_CYCLES     ((`SLRX_LOCK_NS * `SLRX_CLK_MHZ) / 1000)

`endif

// [core/slrx_setup_regs.v]
// receiver setup register bank: datapath, transport and physical layer steps,
// reached over a four-wire serial control port sampled by ref_clk
// assumes sclk runs at most a quarter of ref_clk and all pins are synchronous
//
// How it works
// - format bit 7 picks two's complement or unsigned
// - interpolation register holds selected interpolation setting
// - link parameter fields store value minus one
// - version field one means B, zero A
// - writing zero to power register powers interface
// - recovery reset zero holds, one releases recovery
// - recovery config bit5 half rate, bit1 oversample
// - divider bit2 set, bits1:0 pll division
// - writing one to pll enable starts pll
// - equalizer bits7:6 mode, low bits default 0x22
// - deskew and enable registers hold per-lane masks
// - link control bits pick checksum, dual, page
// - pll status bit0 reads one once locked
`include "slrx_defines.vh"

module slrx_setup_regs #(
   parameter LOCK_CYCLES = `SLRX_LOCK_CYCLES,
   parameter NCOM        = 32,
   parameter NLNK        = 15
) (
   input  wire       ref_clk,
   input  wire       rstn,
   input  wire       cs_n,
   input  wire       sclk,
   input  wire       sdi,
   output wire       sdo,
   output wire       sdo_oe,
   output wire       sample_format_sel,
   output wire [7:0] interpolation_sel,
   output wire       serial_iface_on,
   output wire [7:0] idle_lane_mask,
   output wire       recovery_hold,
   output wire       half_rate_sel,
   output wire       oversample_sel,
   output wire [1:0] serial_pll_ratio,
   output wire       serial_pll_run,
   output wire       serial_pll_locked,
   output wire [1:0] equalizer_sel,
   output wire       sum_method_sel,
   output wire       two_link_sel,
   output wire       link_page_sel,
   output wire [7:0] link0_lane_enable,
   output wire [7:0] link1_lane_enable,
   output wire [7:0] link0_lane_deskew,
   output wire [7:0] link1_lane_deskew,
   output wire       link0_version_b,
   output wire       link1_version_b
);

   // ============================================================
   // register tables
   // offset of each shared register, by index
   function [14:0] com_addr;
      input integer i;
      begin
         case (i)
            0:  com_addr = `SLRX_SAMPLE_FORMAT;
            1:  com_addr = `SLRX_INTERP_SELECT;
            2:  com_addr = `SLRX_IFACE_POWER;
            3:  com_addr = `SLRX_UNUSED_LANES;
            4:  com_addr = `SLRX_RECOVERY_RESET;
            5:  com_addr = `SLRX_RECOVERY_CFG;
            6:  com_addr = `SLRX_EQUALIZER;
            7:  com_addr = `SLRX_PLL_ENABLE;
            8:  com_addr = `SLRX_PLL_FILTER_A;
            9:  com_addr = `SLRX_PLL_FILTER_B;
            10: com_addr = `SLRX_PLL_FILTER_C;
            11: com_addr = `SLRX_PLL_PUMP_A;
            12: com_addr = `SLRX_PLL_DIVIDER;
            13: com_addr = `SLRX_PLL_VCO_LDO;
            14: com_addr = `SLRX_PLL_CONFIG_A;
            15: com_addr = `SLRX_PLL_VARACTOR_A;
            16: com_addr = `SLRX_PLL_PUMP_B;
            17: com_addr = `SLRX_PLL_VCO_A;
            18: com_addr = `SLRX_PLL_VCO_B;
            19: com_addr = `SLRX_PLL_CONFIG_B;
            20: com_addr = `SLRX_PLL_VARACTOR_B;
            21: com_addr = `SLRX_PLL_PUMP_C;
            22: com_addr = `SLRX_PLL_VARACTOR_C;
            23: com_addr = `SLRX_PLL_VARACTOR_D;
            24: com_addr = `SLRX_AUTOTUNE_A;
            25: com_addr = `SLRX_TERM_A_LOW;
            26: com_addr = `SLRX_TERM_A_HIGH;
            27: com_addr = `SLRX_AUTOTUNE_B;
            28: com_addr = `SLRX_TERM_B_LOW;
            29: com_addr = `SLRX_TERM_B_HIGH;
            30: com_addr = `SLRX_LINK_CONTROL;
            31: com_addr = `SLRX_PORT_CONFIG;
            default: com_addr = `SLRX_PLL_STATUS;
         endcase
      end
   endfunction

   // reset value of each shared register; the fixed fields start at their required values
   function [7:0] com_rst;
      input [14:0] a;
      begin
         case (a)
            `SLRX_RECOVERY_RESET: com_rst = `SLRX_RST_CDR;
            `SLRX_RECOVERY_CFG:   com_rst = `SLRX_RST_RECOVERY;
            `SLRX_PLL_DIVIDER:    com_rst = `SLRX_RST_DIVIDER;
            `SLRX_EQUALIZER:      com_rst = `SLRX_RST_EQUALIZER;
            default:              com_rst = `SLRX_RST_ZERO;
         endcase
      end
   endfunction

   // offset of each per-link register, by index within one link page
   function [14:0] lnk_addr;
      input integer i;
      begin
         case (i)
            0:  lnk_addr = `SLRX_DEVICE_ID;
            1:  lnk_addr = `SLRX_BANK_ID;
            2:  lnk_addr = `SLRX_LANE_ID;
            3:  lnk_addr = `SLRX_LANE_COUNT;
            4:  lnk_addr = `SLRX_OCTETS;
            5:  lnk_addr = `SLRX_FRAMES;
            6:  lnk_addr = `SLRX_CONVERTERS;
            7:  lnk_addr = `SLRX_RESOLUTION;
            8:  lnk_addr = `SLRX_SAMPLE_BITS;
            9:  lnk_addr = `SLRX_VERSION;
            10: lnk_addr = `SLRX_DENSITY;
            11: lnk_addr = `SLRX_LANE_SUM;
            12: lnk_addr = `SLRX_LANE_DESKEW;
            13: lnk_addr = `SLRX_FRAME_OCTETS;
            14: lnk_addr = `SLRX_LANE_ENABLE;
            default: lnk_addr = `SLRX_PLL_STATUS;
         endcase
      end
   endfunction

   // ============================================================
   // serial control port
   // frame: r/w bit (1 = read), 15 address bits, 8 data bits, msb first
   reg        sclk_q_r;
   reg [4:0]  bit_cnt_r;
   reg [22:0] shift_r;
   reg        read_r;
   reg [14:0] addr_r;
   reg [7:0]  rd_shift_r;
   reg        sdo_r;
   reg        sdo_oe_r;
   reg        wr_stb_r;
   reg [7:0]  wr_data_r;
   reg [7:0]  rd_data;

   wire sclk_rise = sclk & ~sclk_q_r;
   wire sclk_fall = ~sclk & sclk_q_r;
   wire [4:0] bit_cnt_inc = bit_cnt_r + 5'h01;

   // shift in on rising sclk; read data goes out on falling sclk so it is
   // stable a half sclk period before the host samples it
   always @(posedge ref_clk) begin
      if (!rstn) begin
         sclk_q_r   <= 1'b0;
         bit_cnt_r  <= 5'h00;
         shift_r    <= 23'h000000;
         read_r     <= 1'b0;
         addr_r     <= 15'h0000;
         rd_shift_r <= 8'h00;
         sdo_r      <= 1'b0;
         sdo_oe_r   <= 1'b0;
         wr_stb_r   <= 1'b0;
         wr_data_r  <= 8'h00;
      end else begin
         sclk_q_r <= sclk;
         wr_stb_r <= 1'b0;
         if (cs_n) begin
            bit_cnt_r <= 5'h00;
            sdo_oe_r  <= 1'b0;
         end else if (sclk_rise && bit_cnt_r != `SLRX_FRAME_BITS) begin
            shift_r   <= {shift_r[21:0], sdi};
            bit_cnt_r <= bit_cnt_inc;
            if (bit_cnt_inc == `SLRX_INSTR_BITS) begin
               read_r <= shift_r[14];
               addr_r <= {shift_r[13:0], sdi};
            end
            // bits after the data byte are ignored; one byte per frame
            if (bit_cnt_inc == `SLRX_FRAME_BITS && !read_r) begin
               wr_stb_r  <= 1'b1;
               wr_data_r <= {shift_r[6:0], sdi};
            end
         end else if (sclk_fall && read_r && bit_cnt_r >= `SLRX_INSTR_BITS
                      && bit_cnt_r != `SLRX_FRAME_BITS) begin
            sdo_oe_r <= 1'b1;
            if (bit_cnt_r == `SLRX_INSTR_BITS) begin
               sdo_r      <= rd_data[7];
               rd_shift_r <= {rd_data[6:0], 1'b0};
            end else begin
               sdo_r      <= rd_shift_r[7];
               rd_shift_r <= {rd_shift_r[6:0], 1'b0};
            end
         end
      end
   end

   // ============================================================
   // register storage
   reg  [7:0] com_r [0:NCOM-1];
   reg  [7:0] lnk_r [0:2*NLNK-1];
   reg        locked_r;
   wire       page = com_r[30][`SLRX_PAGE_BIT];

   // one process per entry; link registers are paged so each link keeps its own set
   genvar gi;
   generate
      for (gi = 0; gi < NCOM; gi = gi + 1) begin : g_com
         always @(posedge ref_clk) begin
            if (!rstn)
               com_r[gi] <= com_rst(com_addr(gi));
            else if (wr_stb_r && addr_r == com_addr(gi))
               com_r[gi] <= wr_data_r;
         end
      end
      for (gi = 0; gi < 2 * NLNK; gi = gi + 1) begin : g_lnk
         always @(posedge ref_clk) begin
            if (!rstn)
               lnk_r[gi] <= `SLRX_RST_ZERO;
            else if (wr_stb_r && addr_r == lnk_addr(gi % NLNK)
                     && page == (gi >= NLNK))
               lnk_r[gi] <= wr_data_r;
         end
      end
   endgenerate

   // read mux: unmapped offsets read as zero, status is read only
   integer ri;
   always @* begin
      rd_data = 8'h00;
      for (ri = 0; ri < NCOM; ri = ri + 1) begin
         if (addr_r == com_addr(ri))
            rd_data = com_r[ri];
      end
      for (ri = 0; ri < NLNK; ri = ri + 1) begin
         if (addr_r == lnk_addr(ri))
            rd_data = page ? lnk_r[ri + NLNK] : lnk_r[ri];
      end
      if (addr_r == `SLRX_PLL_STATUS)
         rd_data = {7'h00, locked_r};
   end

   // ============================================================
   // serial pll lock model
   // lock is reported a fixed time after enable while recovery is released;
   // dropping the enable or re-entering recovery reset clears it at once
   reg [15:0] lock_cnt_r;
   wire       pll_go = com_r[7][`SLRX_LSB_BIT] & com_r[4][`SLRX_LSB_BIT];
   always @(posedge ref_clk) begin
      if (!rstn) begin
         lock_cnt_r <= 16'h0000;
         locked_r   <= 1'b0;
      end else if (!pll_go) begin
         lock_cnt_r <= 16'h0000;
         locked_r   <= 1'b0;
      end else if (lock_cnt_r == LOCK_CYCLES[15:0] - 16'h0001) begin
         locked_r   <= 1'b1;
      end else begin
         lock_cnt_r <= lock_cnt_r + 16'h0001;
      end
   end

   // ============================================================
   // decoded controls, held in flops so every output is registered
   reg pwr_on_r;
   reg cdr_hold_r;
   reg ver_b0_r;
   reg ver_b1_r;
   always @(posedge ref_clk) begin
      if (!rstn) begin
         pwr_on_r   <= 1'b0;
         cdr_hold_r <= 1'b0;
         ver_b0_r   <= 1'b0;
         ver_b1_r   <= 1'b0;
      end else begin
         pwr_on_r   <= (com_r[2] == `SLRX_POWER_ON_VALUE);
         cdr_hold_r <= ~com_r[4][`SLRX_LSB_BIT];
         ver_b0_r   <= (lnk_r[9][`SLRX_VER_RANGE] == `SLRX_VER_B);
         ver_b1_r   <= (lnk_r[9 + NLNK][`SLRX_VER_RANGE] == `SLRX_VER_B);
      end
   end

   // ============================================================
   // outputs
   assign sdo               = sdo_r;
   assign sdo_oe            = sdo_oe_r;
   assign sample_format_sel = com_r[0][`SLRX_FMT_BIT];
   assign interpolation_sel = com_r[1];
   assign serial_iface_on   = pwr_on_r;
   assign idle_lane_mask    = com_r[3];
   assign recovery_hold     = cdr_hold_r;
   assign half_rate_sel     = com_r[5][`SLRX_HALF_BIT];
   assign oversample_sel    = com_r[5][`SLRX_OVERSAMPLE_SEL_BIT];
   assign serial_pll_ratio  = com_r[12][`SLRX_DIV_RANGE];
   assign serial_pll_run    = com_r[7][`SLRX_LSB_BIT];
   assign serial_pll_locked = locked_r;
   assign equalizer_sel     = com_r[6][`SLRX_EQ_RANGE];
   assign sum_method_sel    = com_r[30][`SLRX_SUM_BIT];
   assign two_link_sel      = com_r[30][`SLRX_DUAL_BIT];
   assign link_page_sel     = page;
   assign link0_lane_enable = lnk_r[14];
   assign link1_lane_enable = lnk_r[14 + NLNK];
   assign link0_lane_deskew = lnk_r[12];
   assign link1_lane_deskew = lnk_r[12 + NLNK];
   assign link0_version_b   = ver_b0_r;
   assign link1_version_b   = ver_b1_r;

endmodule // slrx_setup_regs

// [tb/slrx_host_model.sv]
// host side of the serial control port: frames of r/w bit, 15-bit address, one byte
// assumes ref_clk runs free and the bench calls xfer from one process at a time
module slrx_host_model (
   input  wire logic ref_clk,
   output logic      cs_n,
   output logic      sclk,
   output logic      sdi,
   input  wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi  = 1'b0;
   end

   // ============================================================
   // frame task
   // sclk phases last several cycles since the bank samples sclk with ref_clk;
   // nb below 24 cuts the frame short to exercise the abort path
   task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                       input int nb, output logic [7:0] rd_q);
      logic [23:0] f;
      f = {rd, a, wd};
      rd_q = 8'h00;
      @(posedge ref_clk);
      cs_n <= 1'b0;
      for (int k = 23; k >= 24 - nb; k--) begin
         sclk <= 1'b0;
         sdi  <= f[k];
         repeat (3) @(posedge ref_clk);
         if (k < 8) rd_q = {rd_q[6:0], sdo}; // read bit settled after the fall
         sclk <= 1'b1;
         repeat (2) @(posedge ref_clk);
      end
      sclk <= 1'b0;
      sdi  <= ~sdi; // released line shows no stale bit
      repeat (2) @(posedge ref_clk);
      cs_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask
endmodule // slrx_host_model

// [tb/slrx_setup_regs_properties.sv]
// pin-level timing of register stores, page routing, read drive and pll lock
// assumes one ref_clk domain and synchronous active-low rstn
module slrx_setup_regs_properties #(
   parameter int LOCK_CYCLES = 500
) (
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire logic       cs_n,
   input wire logic       sclk,
   input wire logic       sdo,
   input wire logic       sdo_oe,
   input wire logic       sample_format_sel,
   input wire logic [7:0] interpolation_sel,
   input wire logic       serial_iface_on,
   input wire logic       recovery_hold,
   input wire logic       serial_pll_run,
   input wire logic       serial_pll_locked,
   input wire logic       sum_method_sel,
   input wire logic       two_link_sel,
   input wire logic       link_page_sel,
   input wire logic [7:0] link0_lane_enable,
   input wire logic [7:0] link1_lane_enable
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   // ============================================================
   // lock counter: cycles with pll running and recovery released, saturating
   always_comb begin
      cnt_nxt = 8'h00;
      if (serial_pll_run && !recovery_hold) cnt_nxt = (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) cnt_r <= 8'h00;
      else cnt_r <= cnt_nxt;
   end

   // ============================================================
   // a store lands one edge after the 24th sclk rise is seen; decoded flops one more
   sequence s_store;
      $past(sclk, 2) && !$past(sclk, 3) && !$past(cs_n, 2);
   endsequence
   sequence s_store_late;
      $past(sclk, 3) && !$past(sclk, 4) && !$past(cs_n, 3);
   endsequence
   sequence s_lock_loss;
      $fell(serial_pll_run) || $rose(recovery_hold);
   endsequence

   cfg_store_a:
      assert property ($changed({sample_format_sel, interpolation_sel}) && $past(rstn) && $past(rstn, 2) |-> s_store)
      else $error("datapath output moved without a completed write");
   link_ctrl_a:
      assert property ($changed({sum_method_sel, two_link_sel, link_page_sel}) && $past(rstn) && $past(rstn, 2) |-> s_store)
      else $error("link control output moved without a completed write");
   iface_power_a:
      assert property ($changed(serial_iface_on) && $past(rstn) && $past(rstn, 2) |-> s_store_late)
      else $error("interface power moved out of step with a write");
   recovery_hold_a:
      assert property ($changed(recovery_hold) && $past(rstn) && $past(rstn, 2) |-> s_store_late)
      else $error("recovery hold moved out of step with a write");
   page0_route_a:
      assert property ($changed(link0_lane_enable) && $past(rstn) |-> !$past(link_page_sel, 2))
      else $error("first link lanes changed while second page selected");
   page1_route_a:
      assert property ($changed(link1_lane_enable) && $past(rstn) |-> $past(link_page_sel, 2))
      else $error("second link lanes changed while first page selected");
   read_release_a:
      assert property ($rose(cs_n) |-> ##[1:2] !sdo_oe)
      else $error("read drive kept after deselect");
   sdo_shift_a:
      assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !$past(sclk, 1) && $past(sclk, 2))
      else $error("read bit changed without a serial clock fall");
   lock_early_a:
      assert property ($rose(serial_pll_locked) |-> cnt_r >= LOCK_CYCLES - 2)
      else $error("lock reported before the lock time");
   lock_late_a:
      assert property (cnt_r >= LOCK_CYCLES + 3 && !recovery_hold |-> serial_pll_locked)
      else $error("lock not reported after the lock time");
   lock_drop_a:
      assert property (s_lock_loss |-> ##[0:2] !serial_pll_locked)
      else $error("lock kept after pll stop or recovery hold");
endmodule // slrx_setup_regs_properties

// [tb/slrx_setup_regs_tb_top.sv]
// bench for the receiver setup bank: host model frames, array model predicts all results
// assumes host model and property checker compiled first
module slrx_setup_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LCK = 6; // short lock time keeps the run brief
   logic ref_clk, rstn, sdo, sdo_oe, sample_format_sel, serial_iface_on, recovery_hold;
   logic half_rate_sel, oversample_sel, serial_pll_run, serial_pll_locked, sum_method_sel;
   logic two_link_sel, link_page_sel, link0_version_b, link1_version_b;
   logic [7:0] interpolation_sel, idle_lane_mask, link0_lane_enable, link1_lane_enable;
   logic [7:0] link0_lane_deskew, link1_lane_deskew, q;
   logic [1:0] serial_pll_ratio, equalizer_sel;
   wire        cs_n, sclk, sdi;
   logic [7:0] mdl [0:65535]; // second link page lives at +0x8000
   logic [7:0] filt [3] = '{8'h62, 8'hC9, 8'h0E};
   logic [31:0] lfsr = 32'h0000_53EC;
   int fails = 0;
   int compares = 0;
   logic [15:0] amap [$] = '{16'h0110, 16'h0112, 16'h0200, 16'h0201, 16'h0206, 16'h0230,
      16'h0268, 16'h0280, 16'h0281, 16'h0284, 16'h0285, 16'h0286, 16'h0287, 16'h0289, 16'h028A,
      16'h028B, 16'h0290, 16'h0294, 16'h0296, 16'h0297, 16'h0299, 16'h029A, 16'h029C, 16'h029F,
      16'h02A0, 16'h02A7, 16'h02AA, 16'h02AB, 16'h02AE, 16'h02B1, 16'h02B2, 16'h0300, 16'h0314,
      16'h0450, 16'h0451, 16'h0452, 16'h0453, 16'h0454, 16'h0455, 16'h0456, 16'h0457, 16'h0458,
      16'h0459, 16'h045A, 16'h045D, 16'h046C, 16'h0476, 16'h047D};

   slrx_setup_regs #(.LOCK_CYCLES(LCK)) DUT (.ref_clk, .rstn, .cs_n, .sclk, .sdi, .sdo, .sdo_oe,
      .sample_format_sel, .interpolation_sel, .serial_iface_on, .idle_lane_mask, .recovery_hold,
      .half_rate_sel, .oversample_sel, .serial_pll_ratio, .serial_pll_run, .serial_pll_locked,
      .equalizer_sel, .sum_method_sel, .two_link_sel, .link_page_sel, .link0_lane_enable,
      .link1_lane_enable, .link0_lane_deskew, .link1_lane_deskew, .link0_version_b,
      .link1_version_b);
   slrx_host_model host (.ref_clk, .cs_n, .sclk, .sdi, .sdo);

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ============================================================
   // model helpers
   function automatic logic [31:0] nxt(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic bit mapped(logic [15:0] a);
      foreach (amap[i]) if (amap[i] == a) return 1'b1;
      return 1'b0;
   endfunction
   function automatic logic [15:0] pk(logic [15:0] a);
      return (a >= 16'h0450 && a <= 16'h047D && mdl[16'h0300][2]) ? a + 16'h8000 : a;
   endfunction
   function automatic logic [62:0] outv();
      return {sample_format_sel, interpolation_sel, serial_iface_on, idle_lane_mask,
         recovery_hold, half_rate_sel, oversample_sel, serial_pll_ratio, serial_pll_run,
         equalizer_sel, sum_method_sel, two_link_sel, link_page_sel, link0_lane_enable,
         link1_lane_enable, link0_lane_deskew, link1_lane_deskew, link0_version_b, link1_version_b};
   endfunction
   function automatic logic [62:0] expv();
      return {mdl[16'h0110][7], mdl[16'h0112], mdl[16'h0200] == 8'h00, mdl[16'h0201],
         !mdl[16'h0206][0], mdl[16'h0230][5], mdl[16'h0230][1], mdl[16'h0289][1:0],
         mdl[16'h0280][0], mdl[16'h0268][7:6], mdl[16'h0300][6], mdl[16'h0300][3],
         mdl[16'h0300][2], mdl[16'h047D], mdl[16'h847D], mdl[16'h046C], mdl[16'h846C],
         mdl[16'h0459][7:5] == 3'h1, mdl[16'h8459][7:5] == 3'h1};
   endfunction
   task automatic mreset();
      foreach (mdl[i]) mdl[i] = 8'h00;
      mdl[16'h0206] = 8'h01;
      mdl[16'h0230] = 8'h08;
      mdl[16'h0289] = 8'h04;
      mdl[16'h0268] = 8'h22;
   endtask
   task automatic chk(input logic [62:0] got, input logic [62:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // writes to unmapped places and to the lock status are dropped
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] r;
      host.xfer(1'b0, a[14:0], d, 24, r);
      if (mapped(a) && a != 16'h0281) mdl[pk(a)] = d;
      chk(outv(), expv());
   endtask
   // lock status is predicted from pll enable and recovery release; a frame outlasts LCK
   task automatic rdc(input logic [15:0] a);
      logic [7:0] r, e;
      host.xfer(1'b1, a[14:0], 8'hA5, 24, r);
      e = (a == 16'h0281) ? {7'h00, mdl[16'h0280][0] & mdl[16'h0206][0]} : mdl[pk(a)];
      chk({55'h0, r}, {55'h0, e});
      if (a == 16'h0281) chk({62'h0, serial_pll_locked}, {62'h0, e[0]});
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ============================================================
   // main sequence
   initial begin
      rstn = 1'b0;
      mreset();
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      foreach (amap[i]) rdc(amap[i]);
      chk(outv(), expv());
      $display("test reset_values done");
      for (int p = 0; p < 2; p++) begin
         foreach (amap[i]) begin
            lfsr = nxt(lfsr);
            if (amap[i] == 16'h0300) wr(amap[i], (lfsr[7:0] & 8'hFB) | {5'h00, p[0], 2'h0});
            else if (amap[i] == 16'h045A) wr(amap[i], lfsr[7:0] & 8'hE0);
            else wr(amap[i], lfsr[7:0]);
         end
         foreach (amap[i]) rdc(amap[i]);
      end
      $display("test random_fill done");
      host.xfer(1'b0, 15'h0112, ~mdl[16'h0112], 20, q); // frame cut short stores nothing
      chk(outv(), expv());
      wr(16'h0115, 8'hFF); // unmapped place
      rdc(16'h0115);
      rdc(16'h0112);
      $display("test refusals done");
      // bring-up order for two links, then lock loss while recovery is held
      wr(16'h0110, 8'h80);
      wr(16'h0112, 8'h03);
      wr(16'h0200, 8'h00);
      wr(16'h0201, 8'hF0);
      for (int p = 0; p < 2; p++) begin
         wr(16'h0300, {5'h09, p[0], 2'h0});
         wr(16'h0450, 8'h3C);
         wr(16'h0451, 8'h05);
         wr(16'h0452, {7'h00, p[0]});
         wr(16'h0453, 8'h83);
         wr(16'h0459, 8'h20);
         wr(16'h045A, 8'h80);
         wr(16'h046C, 8'h0F);
         wr(16'h047D, 8'h0F);
      end
      wr(16'h0459, 8'h00);
      foreach (filt[k]) wr(16'h0284 + 16'(k), filt[k]);
      wr(16'h0230, 8'h2A);
      wr(16'h0206, 8'h00);
      wr(16'h0206, 8'h01);
      wr(16'h0289, 8'h05);
      wr(16'h0268, 8'h62);
      wr(16'h0280, 8'h00);
      rdc(16'h0281);
      wr(16'h0280, 8'h01);
      rdc(16'h0281);
      wr(16'h0206, 8'h00);
      rdc(16'h0281);
      $display("test bring_up done");
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      mreset();
      rstn <= 1'b1;
      foreach (amap[i]) rdc(amap[i]);
      $display("test second_reset done");
      print_verdict();
   end

   // watchdog: the sequence needs about 41000 cycles
   initial begin
      repeat (90000) @(posedge ref_clk);
      fails++;
      print_verdict();
   end
endmodule // slrx_setup_regs_tb_top

bind slrx_setup_regs slrx_setup_regs_properties #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (.ref_clk,
   .rstn, .cs_n, .sclk, .sdo, .sdo_oe, .sample_format_sel, .interpolation_sel, .serial_iface_on,
   .recovery_hold, .serial_pll_run, .serial_pll_locked, .sum_method_sel, .two_link_sel,
   .link_page_sel, .link0_lane_enable, .link1_lane_enable);
